// ===== hw/adc_pkg.sv
package adc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_MASK   = 8'h00;
  localparam logic [7:0] ADDR_MIRROR = 8'h04;
  localparam logic [7:0] ADDR_COUNT  = 8'h08;
  localparam logic [7:0] ADDR_ERROR  = 8'h0C;
  localparam logic [7:0] ADDR_EVENT  = 8'h10;
  localparam logic [7:0] ADDR_CTRL   = 8'h14;
  // event flag positions
  localparam int EV_HALT = 0;
  localparam int EV_ERR  = 1;
  localparam int EV_CNT  = 2;
  localparam int EV_SIZE = 3;
  localparam int EV_W    = 4;
  // control register fields
  localparam int CTRL_SRC = 0;
  localparam int CTRL_RUN = 3;
  localparam int CTRL_ISO = 4;
  // error register fields
  localparam int ERR_AEH = 7;
  localparam int ERR_W   = 7;
  // reset values
  localparam logic [3:0] MASK_RST   = 4'h0;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [6:0] PRESET_RST = 7'h00;
  localparam logic [2:0] SRC_RST    = 3'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // packet sequence states
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b01,
    SEQ_STEP1 = 2'b10
  } adc_seq_t;
endpackage : adc_pkg

// ===== hw/adc_axil.sv
`timescale 1ns/100ps
module adc_axil
  import adc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic             wr_fire,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  input  wire logic        wr_hit,
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_hit
);
  logic wr_lane0;

  // fire once both halves are held; only byte lane 0 carries data
  assign wr_fire = !s_awready && !s_wready && !s_bvalid && wr_lane0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
      wr_addr   <= 8'h00;
      wr_data   <= 8'h00;
      wr_lane0  <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        s_awready <= 1'b0;
        wr_addr   <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        s_wready <= 1'b0;
        wr_data  <= s_wdata[7:0];
        wr_lane0 <= s_wstrb[0];
      end
      if (!s_awready && !s_wready && !s_bvalid) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        wr_lane0 <= 1'b0;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  ///////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= RESP_OKAY;
    end else begin
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0;
        s_rvalid  <= 1'b1;
        s_rdata   <= {24'h00_0000, rd_data};
        s_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_rvalid && s_rready) begin
        s_rvalid  <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end
endmodule : adc_axil

// ===== hw/adc_errcnt.sv
`timescale 1ns/100ps
module adc_errcnt
  import adc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        active,
  input  wire logic        dec,
  input  wire logic        success,
  output logic             auto_error_recovery,
  output logic             zero,
  output logic [7:0]       rd_value
);
  logic [ERR_W-1:0] preset;
  logic [ERR_W-1:0] count;

  assign zero     = (count == 7'h00);
  assign rd_value = {auto_error_recovery, active ? count : preset};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preset <= PRESET_RST;
      auto_error_recovery    <= 1'b0;
    end else if (wr && !active) begin
      preset <= wr_data[ERR_W-1:0];
      auto_error_recovery    <= wr_data[ERR_AEH];
    end
  end

  // outside the mode the live count simply tracks the preset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= PRESET_RST;
    end else if (!active || success) begin
      count <= preset;
    end else if (dec && auto_error_recovery && !zero) begin
      count <= count - 7'h01;
    end
  end

  ///////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  wr_ignored_a: assert property (active && wr |=> $stable(preset))
    else $error("preset changed while auto mode ran");
  ok_reload_a: assert property (active && success |=> count == $past(preset))
    else $error("count not reloaded after success");
  err_floor_a: assert property (zero && !success && active |=> zero)
    else $error("error count went below zero");
endmodule : adc_errcnt

// ===== hw/adc_top.sv
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Functional notes
// - each masked-in event sets the alternate event dma bit
// - mirror is read only; reading it disturbs no endpoint status
// - mirror shows selected endpoint status regardless of dma state
// - packet count decrements per completed operation, stops at zero
// - at zero, the next completed operation sets count done
// - receive: count after good reception then dma to memory
// - transmit: count after dma fetch then good transmission
// - software write to packet count beats a same-cycle decrement
// - error counter decrements per bus error only in mode with recovery
// - error counter reloads after success and when mode stops
// - further error at zero sets transfer error; no underflow
// - error register writes ignored while auto mode runs
// - error read gives live count in mode, preset otherwise
// - non-iso transmit error with recovery reloads fifo to resend
// - non-iso receive error with recovery flushes fifo for resend
// - iso receive error with recovery drops packet and flushes fifo
// - recovery bit clear stops all retry and flush handling
// - any event stops auto mode; restart needs all events clear
// - toggle mismatch, or bad packet without recovery or at zero, sets transfer error
module adc_top
  import adc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  input  wire logic [63:0] endpoint_status,
  input  wire logic        dma_done,
  input  wire logic        bus_ok,
  input  wire logic        bus_err,
  input  wire logic        toggle_mismatch,
  input  wire logic        short_packet,
  output logic             alt_dma_set,
  output logic             auto_active,
  output logic             fifo_reload,
  output logic             fifo_flush
);
  logic             wr_fire;
  logic [7:0]       wr_addr;
  logic [7:0]       wr_data;
  logic             wr_hit;
  logic [7:0]       rd_data;
  logic             rd_hit;
  logic [3:0]       mask;
  logic [7:0]       count;
  logic [EV_W-1:0]  events;
  logic [EV_W-1:0]  ev_set;
  logic [EV_W-1:0]  ev_clr;
  logic [2:0]       src;
  logic             iso;
  logic             dir_rx;
  logic             auto_error_recovery;
  logic             err_zero;
  logic [7:0]       err_rd;
  logic             cnt_wr;
  logic             ev_wr;
  logic             ctl_wr;
  logic             err_wr;
  logic             start;
  logic             stop_sw;
  logic             step_a;
  logic             step_b;
  logic             op_done;
  logic             err_seen;
  adc_seq_t         seq;
  adc_seq_t         next_seq;

  adc_axil u_bus (
    .clk       (clk),
    .rst_n     (rst_n),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_fire   (wr_fire),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_hit    (wr_hit),
    .rd_data   (rd_data),
    .rd_hit    (rd_hit)
  );

  adc_errcnt u_err (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr       (err_wr),
    .wr_data  (wr_data),
    .active   (auto_active),
    .dec      (err_seen),
    .success  (auto_active && bus_ok),
    .auto_error_recovery      (auto_error_recovery),
    .zero     (err_zero),
    .rd_value (err_rd)
  );

  ///////////////////////////////////////////////////////////////////
  // decode; the mirror is not writable and its read has no side effect
  assign cnt_wr = wr_fire && wr_addr == ADDR_COUNT;
  assign err_wr = wr_fire && wr_addr == ADDR_ERROR;
  assign ev_wr  = wr_fire && wr_addr == ADDR_EVENT;
  assign ctl_wr = wr_fire && wr_addr == ADDR_CTRL;

  always_comb begin
    wr_hit = 1'b1;
    unique case (wr_addr)
      ADDR_MASK, ADDR_COUNT, ADDR_ERROR, ADDR_EVENT, ADDR_CTRL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 8'h00;
    unique case (s_araddr)
      ADDR_MASK:   rd_data = {4'h0, mask};
      ADDR_MIRROR: rd_data = endpoint_status[{src, 3'h0} +: 8];
      ADDR_COUNT:  rd_data = count;
      ADDR_ERROR:  rd_data = err_rd;
      ADDR_EVENT:  rd_data = {4'h0, events};
      ADDR_CTRL:   rd_data = {3'h0, iso, auto_active, src};
      default:     rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= MASK_RST;
    end else if (wr_fire && wr_addr == ADDR_MASK) begin
      mask <= wr_data[3:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src <= SRC_RST;
      iso <= 1'b0;
    end else if (ctl_wr) begin
      src <= wr_data[CTRL_SRC +: 3];
      iso <= wr_data[CTRL_ISO];
    end
  end

  ///////////////////////////////////////////////////////////////////
  // odd selects are receive endpoints
  assign dir_rx = src[0];
  assign step_a = dir_rx ? bus_ok : dma_done;
  assign step_b = dir_rx ? dma_done : bus_ok;
  assign op_done = auto_active && seq == SEQ_STEP1 && step_b;
  assign err_seen = auto_active && bus_err;

  always_comb begin
    next_seq = seq;
    unique case (seq)
      SEQ_IDLE:  if (auto_active && step_a) next_seq = SEQ_STEP1;
      SEQ_STEP1: if (!auto_active || step_b) next_seq = SEQ_IDLE;
      default:   next_seq = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq <= SEQ_IDLE;
    end else begin
      seq <= next_seq;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= COUNT_RST;
    end else if (cnt_wr) begin
      count <= wr_data;
    end else if (op_done && count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  ///////////////////////////////////////////////////////////////////
  // events: hardware set beats a same-cycle write-one clear
  assign stop_sw = ctl_wr && auto_active && !wr_data[CTRL_RUN];
  assign start = ctl_wr && !auto_active && wr_data[CTRL_RUN]
                 && events == 4'h0 && ev_set == 4'h0;
  assign ev_clr = ev_wr ? wr_data[EV_W-1:0] : 4'h0;

  always_comb begin
    ev_set = 4'h0;
    ev_set[EV_HALT] = stop_sw;
    ev_set[EV_CNT]  = op_done && count == 8'h00;
    ev_set[EV_SIZE] = auto_active && dir_rx && short_packet;
    ev_set[EV_ERR]  = auto_active && (toggle_mismatch
                      || (bus_err && (!auto_error_recovery || err_zero)));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      events <= 4'h0;
    end else begin
      events <= (events & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_dma_set <= 1'b0;
    end else begin
      alt_dma_set <= |(ev_set & mask);
    end
  end

  // stop takes effect on the same edge that latches the event flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_active <= 1'b0;
    end else if (auto_active) begin
      auto_active <= !(stop_sw || events != 4'h0 || ev_set != 4'h0);
    end else begin
      auto_active <= start;
    end
  end

  // recovery pulses; nothing fires with the recovery bit clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_reload <= 1'b0;
      fifo_flush  <= 1'b0;
    end else begin
      fifo_reload <= err_seen && auto_error_recovery && !dir_rx && !iso;
      fifo_flush  <= err_seen && auto_error_recovery && dir_rx;
    end
  end

  ///////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_tx_err;
    auto_active && bus_err && auto_error_recovery && !dir_rx && !iso;
  endsequence

  sequence s_rx_err;
    auto_active && bus_err && auto_error_recovery && dir_rx;
  endsequence

  mask_gate_a: assert property (alt_dma_set |-> $past(|(ev_set & mask)))
    else $error("dma bit set without an enabled event");
  count_floor_a: assert property (count == 8'h00 && !cnt_wr |=> count == 8'h00)
    else $error("packet count wrapped");
  count_dec_a: assert property (op_done && !cnt_wr && count != 8'h00
                                |=> count == $past(count) - 8'h01)
    else $error("packet count did not step down");
  count_done_a: assert property (op_done && count == 8'h00 |=> events[EV_CNT])
    else $error("count done not flagged");
  write_wins_a: assert property (cnt_wr |=> count == $past(wr_data))
    else $error("packet count write lost");
  stop_event_a: assert property (auto_active && ev_set != 4'h0 |=> !auto_active)
    else $error("auto mode ran with an event set");
  no_restart_a: assert property (!auto_active && events != 4'h0 |=> !auto_active)
    else $error("auto mode started with an event set");
  err_event_a: assert property (auto_active && bus_err && auto_error_recovery && err_zero
                                |=> events[EV_ERR])
    else $error("error at zero not flagged");
  tx_reload_a: assert property (s_tx_err |=> fifo_reload)
    else $error("no fifo reload on transmit error");
  rx_flush_a: assert property (s_rx_err |=> fifo_flush)
    else $error("no fifo flush on receive error");
  no_recover_a: assert property (!auto_error_recovery |=> !fifo_reload && !fifo_flush)
    else $error("recovery with recovery bit clear");
endmodule : adc_top

// ===== testbench/adc_link_model.sv
`timescale 1ns/100ps
module adc_link_model (
  input  wire logic        clk,
  output logic [63:0]      endpoint_status,
  output logic             dma_done,
  output logic             bus_ok,
  output logic             bus_err,
  output logic             toggle_mismatch,
  output logic             short_packet
);
  logic [4:0] pls  = 5'h00;
  logic [7:0] salt = 8'h00;

  assign dma_done        = pls[0];
  assign bus_ok          = pls[1];
  assign bus_err         = pls[2];
  assign toggle_mismatch = pls[3];
  assign short_packet    = pls[4];

  // every endpoint byte differs, so a wrong source select cannot hide
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      endpoint_status[8*i +: 8] = (8'h1D * 8'(i + 1)) ^ salt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // live status change, so the mirror must follow rather than latch
  task automatic set_salt(input logic [7:0] s);
    salt <= s;
  endtask : set_salt

  task automatic fire(input int k);
    @(posedge clk);
    pls <= 5'(1 << k);
    @(posedge clk);
    pls <= 5'h00;
  endtask : fire

  // kinds: 0 tx packet, 1 rx packet, 2 bus error, 3 toggle mismatch, 4 short packet
  task automatic send(input int kind);
    if (kind == 0) begin
      fire(0); // fetch from memory first, then the host accepts it
      fire(1);
    end else if (kind == 1) begin
      fire(1); // good reception first, then the move to memory
      fire(0);
    end else begin
      fire(kind);
    end
  endtask : send
endmodule : adc_link_model

// ===== testbench/tb_auto_dma_count_error_control.sv
`timescale 1ns/100ps
module tb_auto_dma_count_error_control
  import adc_pkg::*;
;
  logic        clk, rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;
  logic [63:0] endpoint_status;
  logic        dma_done, bus_ok, bus_err, toggle_mismatch, short_packet;
  logic        alt_dma_set, auto_active, fifo_reload, fifo_flush;
  int          num_errors, samples_checked, cycles, alt_n, rel_n, fl_n;
  logic [3:0]  strb;

  adc_top dut_u (
    .clk, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .endpoint_status, .dma_done, .bus_ok,
    .bus_err, .toggle_mismatch, .short_packet, .alt_dma_set, .auto_active,
    .fifo_reload, .fifo_flush
  );

  adc_link_model link_u (
    .clk, .endpoint_status, .dma_done, .bus_ok, .bus_err, .toggle_mismatch, .short_packet
  );

  always #25 clk = ~clk;

  // pulse outputs stand one cycle, so they are counted at every edge
  always @(posedge clk) begin
    cycles++;
    if (alt_dma_set === 1'b1) alt_n++;
    if (fifo_reload === 1'b1) rel_n++;
    if (fifo_flush === 1'b1) fl_n++;
    if (cycles == 8000) begin
      num_errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    s_awaddr  <= a;
    s_wdata   <= {24'h000000, d};
    s_wstrb   <= strb;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : rd

  task automatic exp_rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, {24'h000000, e});
    chk(32'(r), 32'(RESP_OKAY));
  endtask : exp_rd

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    exp_rd(ADDR_MASK, 8'h00);
    exp_rd(ADDR_COUNT, 8'h00);
    exp_rd(ADDR_ERROR, 8'h00);
    exp_rd(ADDR_EVENT, 8'h00);
    wr(ADDR_MIRROR, 8'hFF, r);
    chk(32'(r), 32'(RESP_SLVERR));
    exp_rd(ADDR_MIRROR, 8'h1D);
    rd(8'h18, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h00000000);
    wr(ADDR_MASK, 8'hFF, r);
    exp_rd(ADDR_MASK, 8'h0F);
  endtask : t_reset

  task automatic t_mirror;
    logic [1:0] r;
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CTRL, 8'(i), r);
      exp_rd(ADDR_MIRROR, 8'h1D * 8'(i + 1));
    end
    link_u.set_salt(8'hA5);
    exp_rd(ADDR_MIRROR, (8'h1D * 8'h08) ^ 8'hA5);
    link_u.set_salt(8'h00);
  endtask : t_mirror

  task automatic t_count;
    logic [1:0] r;
    int         a0;
    a0 = alt_n;
    wr(ADDR_EVENT, 8'h0F, r);
    wr(ADDR_MASK, 8'h04, r);
    wr(ADDR_COUNT, 8'h01, r); // two packets, loaded as packets minus one
    wr(ADDR_CTRL, 8'h08, r);
    link_u.send(0);
    exp_rd(ADDR_COUNT, 8'h00);
    chk(32'(auto_active), 32'h1);
    chk(32'(alt_n - a0), 32'h0);
    link_u.send(0);
    exp_rd(ADDR_COUNT, 8'h00);
    exp_rd(ADDR_EVENT, 8'h04);
    chk(32'(auto_active), 32'h0);
    chk(32'(alt_n - a0), 32'h1);
    wr(ADDR_CTRL, 8'h09, r);
    exp_rd(ADDR_EVENT, 8'h04);
    chk(32'(auto_active), 32'h0);
    wr(ADDR_EVENT, 8'h0F, r);
    wr(ADDR_CTRL, 8'h09, r);
    link_u.send(1);
    exp_rd(ADDR_EVENT, 8'h04);
    wr(ADDR_EVENT, 8'h0F, r);
  endtask : t_count

  task automatic t_err;
    logic [1:0] r;
    int         a0, r0;
    a0 = alt_n;
    r0 = rel_n;
    wr(ADDR_MASK, 8'h02, r);
    wr(ADDR_COUNT, 8'hFF, r);
    wr(ADDR_ERROR, 8'h82, r); // three attempts, preset as attempts minus one
    wr(ADDR_CTRL, 8'h08, r);
    link_u.send(2);
    exp_rd(ADDR_ERROR, 8'h81);
    chk(32'(rel_n - r0), 32'h1);
    wr(ADDR_ERROR, 8'h85, r);
    exp_rd(ADDR_ERROR, 8'h81);
    link_u.send(0);
    exp_rd(ADDR_ERROR, 8'h82);
    exp_rd(ADDR_COUNT, 8'hFE);
    link_u.send(2);
    link_u.send(2);
    exp_rd(ADDR_ERROR, 8'h80);
    chk(32'(auto_active), 32'h1);
    link_u.send(2);
    exp_rd(ADDR_EVENT, 8'h02);
    exp_rd(ADDR_ERROR, 8'h82);
    chk(32'(alt_n - a0), 32'h1);
    wr(ADDR_EVENT, 8'h0F, r);
  endtask : t_err

  task automatic t_norec;
    logic [1:0] r;
    int         a0, r0, f0;
    a0 = alt_n;
    r0 = rel_n;
    f0 = fl_n;
    wr(ADDR_MASK, 8'h00, r);
    wr(ADDR_ERROR, 8'h05, r);
    // bus error, toggle mismatch and short packet, each with every mask bit clear
    for (int i = 2; i < 5; i++) begin
      wr(ADDR_CTRL, 8'h09, r);
      link_u.send(i);
      exp_rd(ADDR_EVENT, (i == 4) ? 8'h08 : 8'h02);
      chk(32'(auto_active), 32'h0);
      wr(ADDR_EVENT, 8'h0F, r);
    end
    chk(32'(rel_n - r0), 32'h0);
    chk(32'(fl_n - f0), 32'h0);
    chk(32'(alt_n - a0), 32'h0);
  endtask : t_norec

  task automatic t_flush;
    logic [1:0] r;
    int         a0, f0;
    a0 = alt_n;
    f0 = fl_n;
    wr(ADDR_MASK, 8'h01, r);
    wr(ADDR_ERROR, 8'h83, r);
    wr(ADDR_CTRL, 8'h19, r);
    link_u.send(2);
    exp_rd(ADDR_ERROR, 8'h82);
    chk(32'(fl_n - f0), 32'h1);
    wr(ADDR_CTRL, 8'h01, r);
    exp_rd(ADDR_EVENT, 8'h01);
    exp_rd(ADDR_ERROR, 8'h83);
    wr(ADDR_EVENT, 8'h0F, r);
    wr(ADDR_CTRL, 8'h09, r);
    link_u.send(2);
    exp_rd(ADDR_ERROR, 8'h82);
    chk(32'(fl_n - f0), 32'h2);
    wr(ADDR_CTRL, 8'h01, r);
    exp_rd(ADDR_EVENT, 8'h01);
    chk(32'(alt_n - a0), 32'h2);
    wr(ADDR_EVENT, 8'h0F, r);
  endtask : t_flush

  // lane 0 strobe off writes nothing; iso transmit errors get no recovery
  task automatic t_iso_tx;
    logic [1:0] r;
    int         r0, f0;
    r0 = rel_n;
    f0 = fl_n;
    wr(ADDR_MASK, 8'h00, r);
    strb = 4'hE;
    wr(ADDR_MASK, 8'h0F, r);
    strb = 4'hF;
    chk(32'(r), 32'(RESP_OKAY));
    exp_rd(ADDR_MASK, 8'h00);
    wr(ADDR_ERROR, 8'h81, r);
    wr(ADDR_CTRL, 8'h18, r);
    link_u.send(2);
    exp_rd(ADDR_ERROR, 8'h80);
    chk(32'(rel_n - r0), 32'h0);
    chk(32'(fl_n - f0), 32'h0);
    wr(ADDR_CTRL, 8'h10, r);
    exp_rd(ADDR_EVENT, 8'h01);
    chk(32'(auto_active), 32'h0);
    wr(ADDR_EVENT, 8'h0F, r);
  endtask : t_iso_tx

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk       = 1'b0;
    rst_n     = 1'b0;
    s_awaddr  = 8'h00;
    s_araddr  = 8'h00;
    s_wdata   = 32'h00000000;
    strb      = 4'hF;
    s_wstrb   = strb;
    s_awvalid = 1'b0;
    s_wvalid  = 1'b0;
    s_bready  = 1'b0;
    s_arvalid = 1'b0;
    s_rready  = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_mirror();
    t_count();
    t_err();
    t_norec();
    t_flush();
    t_iso_tx();
    finish_test();
  end
endmodule : tb_auto_dma_count_error_control
